/* File: logic/hps_los_mon.sv */
/*
 * Activity monitor for one synchronised clock input: reports loss when
 * no edge is seen for LOS_TIMEOUT_CYC cycles.
 * Assumes the monitored clock is already synchronised to clk_in.
 */
module hps_los_mon
    import hps_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic mon_clk_in,
    output logic clock_lost_n_out
);

    logic prev_ff;
    logic [LOS_CNT_W-1:0] idle_cnt_ff;
    logic lost_n_ff;
    logic edge_seen;

    assign edge_seen = mon_clk_in ^ prev_ff;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prev_ff <= 1'b0;
            idle_cnt_ff <= '0;
            lost_n_ff <= 1'b0;
        end else begin
            prev_ff <= mon_clk_in;
            if (edge_seen) begin
                idle_cnt_ff <= '0;
                lost_n_ff <= 1'b1;
            end else if (idle_cnt_ff >= LOS_CNT_MAX) begin
                lost_n_ff <= 1'b0;
            end else begin
                idle_cnt_ff <= LOS_CNT_W'(idle_cnt_ff + 1'b1);
            end
        end
    end

    assign clock_lost_n_out = lost_n_ff;

endmodule

/* File: logic/hps_pkg.sv */
/*
 * Package for the host port and status pin block: modes, pin groups,
 * reset values and cycle counts.
 * Assumes a single 10 MHz clock domain and an active-low async reset.
 */
package hps_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned NUM_INPUTS = 3;
    localparam logic [4:0] I2C_ADDR_UPPER_RST = 5'h1A;
    localparam logic SPI_4WIRE_RST = 1'b1;
    localparam int unsigned LOS_TIMEOUT_NS = 200_000;
    localparam int unsigned LOS_TIMEOUT_CYC = LOS_TIMEOUT_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned LOS_CNT_W = 12;
    localparam logic [LOS_CNT_W-1:0] LOS_CNT_MAX = 12'(LOS_TIMEOUT_CYC);
    localparam int unsigned SYNC_W = 2;
    localparam int unsigned STATUS_W = 1 + NUM_INPUTS;

    typedef enum logic [1:0] {
        HPS_MODE_I2C,
        HPS_MODE_SPI3,
        HPS_MODE_SPI4
    } hps_mode_e;

    typedef struct packed {
        logic data_out;
        logic data_oe;
        logic sdo_out;
        logic sdo_oe;
        logic bit_data_in;
        logic frame_active;
    } hps_pins_s;

    typedef struct packed {
        logic [2:0] input_lost_n;
        logic lock_lost_n;
    } hps_status_s;

endpackage

/* File: logic/hps_sync.sv */
/*
 * Two-flop synchroniser, one per bit, for pins arriving from outside.
 * Assumes the inputs are asynchronous levels.
 */
module hps_sync
    import hps_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] rst_val_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff ^ rst_val_in;

endmodule

/* File: logic/hps_top.sv */
/*
 * Host port and status pins of the clock generator: serial mode select,
 * shared pin steering, output disable, lock and loss-of-signal outputs,
 * and the status-change interrupt pin.
 * Assumes the serial protocol engine sits beside it on clk_in and that
 * the PLL and input monitors supply raw status levels.
 */
// What this block does
// - Mode select pin high means I2C, low means SPI.
// - Data pin is SDA in I2C, bidirectional in 3-wire, input in 4-wire.
// - I2C reads second shared pin as address bit 1; 4-wire SPI drives SDO.
// - Host serial clock pin is the bit clock in both modes.
// - I2C reads first shared pin as address bit 0.
// - SPI frames by active-low chip select; respond only while it is low.
// - Interrupt pin goes low on any status change once the straps are taken.
// - Reset low returns all logic and registers to defaults.
// - Clock outputs stay disabled during reset.
// - Output-disable high turns all clock outputs off.
// - Lock output high when locked, low when out of lock.
// - Each loss-of-signal output low on lost input activity.
module hps_top
    import hps_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic serial_mode_sel_in,
    input wire logic serial_clk_in,
    input wire logic cs_addr0_in,
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe_out,
    input wire logic sdo_addr1_in,
    output logic sdo_addr1_out,
    output logic sdo_addr1_oe_out,
    input wire logic output_disable_in,
    input wire logic pll_locked_in,
    input wire logic [NUM_INPUTS-1:0] ref_clk_in,
    input wire logic spi_4wire_wr_in,
    input wire logic spi_4wire_val_in,
    input wire logic irq_clear_in,
    input wire logic eng_rd_data_in,
    input wire logic eng_rd_oe_in,
    input wire logic eng_sda_low_in,
    output logic bit_clk_rise_out,
    output logic bit_clk_fall_out,
    output logic bit_data_out,
    output logic frame_active_out,
    output hps_mode_e mode_out,
    output logic [6:0] i2c_target_addr_out,
    output logic clk_outputs_en_out,
    output logic status_change_irq_n_out,
    output logic lock_lost_n_out,
    output logic input0_clock_lost_n_out,
    output logic input1_clock_lost_n_out,
    output logic input2_clock_lost_n_out
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam int unsigned PIN_W = 7 + NUM_INPUTS;

    logic [PIN_W-1:0] pins_async;
    logic [PIN_W-1:0] pins_sync;
    logic mode_sel_s, sclk_s, csn_s, data_s, a1_s, oe_dis_s, locked_s;
    logic [NUM_INPUTS-1:0] ref_s;

    assign pins_async = {ref_clk_in, pll_locked_in, output_disable_in, sdo_addr1_in,
                         data_pin_in, cs_addr0_in, serial_clk_in, serial_mode_sel_in};
    assign {ref_s, locked_s, oe_dis_s, a1_s, data_s, csn_s, sclk_s, mode_sel_s} = pins_sync;

    hps_sync #(
        .WIDTH(PIN_W)
    ) u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in(pins_async),
        .rst_val_in('0),
        .sync_out(pins_sync)
    );

    // ****************************************
    // Start-up settling
    // ****************************************
    logic [1:0] settle_ff;
    logic settled;

    // Synchronisers hold reset values until SYNC_W edges after release
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            settle_ff <= 2'h0;
        end else if (!settled) begin
            settle_ff <= settle_ff + 2'h1;
        end
    end

    assign settled = (settle_ff == 2'(SYNC_W));

    // ****************************************
    // Mode selection and configuration
    // ****************************************
    logic spi_4wire_ff;
    logic [4:0] addr_upper_ff;
    logic straps_taken_ff;
    logic mode_i2c_ff;
    logic [1:0] addr_strap_ff;
    hps_mode_e mode;

    // Config bit, 4-wire after reset
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            spi_4wire_ff <= SPI_4WIRE_RST;
            addr_upper_ff <= I2C_ADDR_UPPER_RST;
        end else if (spi_4wire_wr_in) begin
            spi_4wire_ff <= spi_4wire_val_in;
        end
    end

    // Straps caught once after reset release, from synchronised pins
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            straps_taken_ff <= 1'b0;
            mode_i2c_ff <= 1'b1;
            addr_strap_ff <= 2'h0;
        end else if (!straps_taken_ff && settled) begin
            straps_taken_ff <= 1'b1;
            mode_i2c_ff <= mode_sel_s;
            addr_strap_ff <= {a1_s, csn_s};
        end
    end

    always_comb begin
        if (mode_i2c_ff) begin
            mode = HPS_MODE_I2C;
        end else if (spi_4wire_ff) begin
            mode = HPS_MODE_SPI4;
        end else begin
            mode = HPS_MODE_SPI3;
        end
    end

    assign mode_out = mode;
    assign i2c_target_addr_out = {addr_upper_ff, addr_strap_ff};

    // ****************************************
    // Bit clock and framing
    // ****************************************
    logic sclk_prev_ff;
    logic frame_active;
    logic edge_ok;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sclk_prev_ff <= 1'b0;
        end else begin
            sclk_prev_ff <= sclk_s;
        end
    end

    // SPI responds only while select is low; I2C is always listening
    assign frame_active = (mode == HPS_MODE_I2C) | ~csn_s;
    assign frame_active_out = frame_active;
    // No edges before straps are taken: an idle-high clock would look like a rise
    assign edge_ok = frame_active & straps_taken_ff;
    assign bit_clk_rise_out = edge_ok & sclk_s & ~sclk_prev_ff;
    assign bit_clk_fall_out = edge_ok & ~sclk_s & sclk_prev_ff;
    assign bit_data_out = data_s;

    // ****************************************
    // Shared pin steering
    // ****************************************
    hps_pins_s pins;

    always_comb begin
        pins = '0;
        pins.bit_data_in = data_s;
        pins.frame_active = frame_active;
        unique case (mode)
            HPS_MODE_I2C: begin
                // Open drain: only ever pull low
                pins.data_oe = eng_sda_low_in;
            end
            HPS_MODE_SPI3: begin
                pins.data_out = eng_rd_data_in;
                pins.data_oe = eng_rd_oe_in & ~csn_s;
            end
            HPS_MODE_SPI4: begin
                pins.sdo_out = eng_rd_data_in;
                pins.sdo_oe = ~csn_s;
            end
            default: begin
                pins.data_oe = 1'b0;
            end
        endcase
    end

    assign data_pin_out = pins.data_out;
    assign data_pin_oe_out = pins.data_oe;
    assign sdo_addr1_out = pins.sdo_out;
    assign sdo_addr1_oe_out = pins.sdo_oe;

    // ****************************************
    // Output enable
    // ****************************************
    logic clk_en_ff;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clk_en_ff <= 1'b0;
        end else begin
            // Held off until the disable pin has passed the synchroniser
            clk_en_ff <= straps_taken_ff & ~oe_dis_s;
        end
    end

    assign clk_outputs_en_out = clk_en_ff;

    // ****************************************
    // Status outputs and interrupt
    // ****************************************
    logic [NUM_INPUTS-1:0] los_n;
    hps_status_s status_ff;
    logic irq_n_ff;
    logic status_changed;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_los
            hps_los_mon u_los (
                .clk_in(clk_in),
                .resetn_in(resetn_in),
                .mon_clk_in(ref_s[gi]),
                .clock_lost_n_out(los_n[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_ff <= '0;
        end else begin
            status_ff.lock_lost_n <= locked_s;
            status_ff.input_lost_n <= los_n;
        end
    end

    assign status_changed = straps_taken_ff &&
                            (status_ff != hps_status_s'({los_n, locked_s}));

    // Set wins over clear
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_n_ff <= 1'b1;
        end else if (status_changed) begin
            irq_n_ff <= 1'b0;
        end else if (irq_clear_in) begin
            irq_n_ff <= 1'b1;
        end
    end

    assign status_change_irq_n_out = irq_n_ff;
    assign lock_lost_n_out = status_ff.lock_lost_n;
    assign input0_clock_lost_n_out = status_ff.input_lost_n[0];
    assign input1_clock_lost_n_out = status_ff.input_lost_n[1];
    assign input2_clock_lost_n_out = status_ff.input_lost_n[2];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    mode_select_a: assert property (
        straps_taken_ff |-> ((mode == HPS_MODE_I2C) == mode_i2c_ff))
        else $error("mode does not follow select strap");
    strap_wait_a: assert property (
        !settled |=> !straps_taken_ff)
        else $error("straps taken before pins settled");
    sda_open_drain_a: assert property (
        (mode == HPS_MODE_I2C) |-> !data_pin_out && !sdo_addr1_oe_out)
        else $error("I2C data pin driven high");
    sdo_drive_a: assert property (
        (mode == HPS_MODE_SPI4) |-> (sdo_addr1_oe_out == !csn_s) && !data_pin_oe_out)
        else $error("4-wire SDO enable wrong");
    bit_clock_a: assert property (
        bit_clk_rise_out |-> $past(sclk_s) == 1'b0 && sclk_s)
        else $error("bit clock edge not from serial clock");
    strap_addr_a: assert property (
        $rose(straps_taken_ff) |-> i2c_target_addr_out[1:0] == $past({a1_s, csn_s}))
        else $error("address straps not captured");
    select_frame_a: assert property (
        (mode != HPS_MODE_I2C) && csn_s |->
            !data_pin_oe_out && !sdo_addr1_oe_out && !bit_clk_rise_out)
        else $error("response outside chip select");
    irq_on_change_a: assert property (
        status_changed |=> !status_change_irq_n_out)
        else $error("interrupt missing on status change");
    irq_hold_a: assert property (
        !status_change_irq_n_out && !irq_clear_in |=> !status_change_irq_n_out)
        else $error("interrupt released without clear");
    out_disable_a: assert property (
        oe_dis_s |=> !clk_outputs_en_out)
        else $error("outputs enabled while disabled");
    out_enable_a: assert property (
        straps_taken_ff && !oe_dis_s |=> clk_outputs_en_out)
        else $error("outputs not enabled while allowed");
    lock_track_a: assert property (
        locked_s |=> lock_lost_n_out)
        else $error("lock output not high when locked");
    los_track_a: assert property (
        status_ff.input_lost_n == $past(los_n, 1))
        else $error("loss output mismatch");
    strap_hold_a: assert property (
        straps_taken_ff |=> $stable(i2c_target_addr_out))
        else $error("target address changed after capture");

    spi4_read_c: cover property ((mode == HPS_MODE_SPI4) && sdo_addr1_oe_out);
    spi3_read_c: cover property ((mode == HPS_MODE_SPI3) && data_pin_oe_out);
    irq_fire_c: cover property ($fell(status_change_irq_n_out));
    los_fall_c: cover property ($fell(input0_clock_lost_n_out));
    frame_end_c: cover property ($fell(frame_active_out));

endmodule

/* File: test/hps_host_model.sv */
/*
 * Host controller model: frames serial transfers on the shared pins.
 * Assumes the bench resolves the shared data and strap wires.
 */
module hps_host_model (
    input wire logic clk_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdi_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    // n serial clocks of 800 ns, select low only when sel is set
    task automatic frame(input int n, input logic val, input logic sel);
        @(negedge clk_in);
        cs_n_out = ~sel;
        sdi_out = val;
        repeat (4) @(negedge clk_in);
        for (int i = 0; i < n; i++) begin
            sclk_out = 1'b1;
            repeat (4) @(negedge clk_in);
            sclk_out = 1'b0;
            repeat (4) @(negedge clk_in);
        end
        cs_n_out = 1'b1;
        // Released data line does not keep its last level
        sdi_out = ~val;
    endtask
endmodule

/* File: test/tb_top.sv */
/*
 * Self-checking bench for the host port and status pin block.
 * Assumes a 10 MHz clock and the host model on the serial pins.
 */
module tb_top;
    import hps_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0, resetn_in = 1'b0, serial_mode_sel_in = 1'b1;
    logic serial_clk_in, cs_addr0_in, data_pin_in, data_pin_out, data_pin_oe_out;
    logic sdo_addr1_in, sdo_addr1_out, sdo_addr1_oe_out, sdi, strap1 = 1'b0;
    logic output_disable_in = 1'b0, pll_locked_in = 1'b0, spi_4wire_wr_in = 1'b0;
    logic spi_4wire_val_in = 1'b1, irq_clear_in = 1'b0, eng_rd_data_in = 1'b0;
    logic eng_rd_oe_in = 1'b0, eng_sda_low_in = 1'b0;
    logic [NUM_INPUTS-1:0] ref_clk_in = '0, ref_run = '0;
    logic bit_clk_rise_out, bit_clk_fall_out, bit_data_out, frame_active_out, clk_outputs_en_out;
    logic status_change_irq_n_out, lock_lost_n_out;
    logic input0_clock_lost_n_out, input1_clock_lost_n_out, input2_clock_lost_n_out;
    logic [6:0] i2c_target_addr_out;
    hps_mode_e mode_out;
    int bad_count = 0, checked = 0, rises = 0, r0, falls = 0, f0;
    // ************************
    // Clocks and pin resolution
    // ************************
    always #50 clk_in = ~clk_in;
    initial #137 forever #400 ref_clk_in = ref_clk_in ^ ref_run;
    always @(posedge clk_in) if (bit_clk_rise_out === 1'b1) rises++;
    always @(posedge clk_in) if (bit_clk_fall_out === 1'b1) falls++;
    assign data_pin_in = data_pin_oe_out ? data_pin_out : (serial_mode_sel_in ? 1'b1 : sdi);
    assign sdo_addr1_in = sdo_addr1_oe_out ? sdo_addr1_out : strap1;
    hps_host_model i_hps_host_model (.clk_in, .sclk_out(serial_clk_in),
        .cs_n_out(cs_addr0_in), .sdi_out(sdi));
    hps_top i_hps_top (.clk_in, .resetn_in, .serial_mode_sel_in, .serial_clk_in,
        .cs_addr0_in, .data_pin_in, .data_pin_out, .data_pin_oe_out, .sdo_addr1_in,
        .sdo_addr1_out, .sdo_addr1_oe_out, .output_disable_in, .pll_locked_in,
        .ref_clk_in, .spi_4wire_wr_in, .spi_4wire_val_in, .irq_clear_in,
        .eng_rd_data_in, .eng_rd_oe_in, .eng_sda_low_in, .bit_clk_rise_out,
        .bit_clk_fall_out, .bit_data_out, .frame_active_out, .mode_out,
        .i2c_target_addr_out, .clk_outputs_en_out, .status_change_irq_n_out,
        .lock_lost_n_out, .input0_clock_lost_n_out, .input1_clock_lost_n_out,
        .input2_clock_lost_n_out);
    // ************************
    // Helpers
    // ************************
    task automatic w(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic do_reset(input logic sel);
        w(1);
        resetn_in = 1'b0;
        serial_mode_sel_in = sel;
        w(16);
        chk("en_rst", clk_outputs_en_out, 0);
        chk("irq_rst", status_change_irq_n_out, 1);
        chk("lock_rst", lock_lost_n_out, 0);
        chk("los_rst", input0_clock_lost_n_out, 0);
        resetn_in = 1'b1;
        w(4);
    endtask
    // ************************
    // Scenarios
    // ************************
    task automatic test_i2c();
        chk("mode", mode_out, HPS_MODE_I2C);
        chk("addr", i2c_target_addr_out, {I2C_ADDR_UPPER_RST, 2'b01});
        chk("sdo_oe", sdo_addr1_oe_out, 0);
        eng_sda_low_in = 1'b1;
        w(4);
        chk("sda_oe", data_pin_oe_out, 1);
        chk("sda", data_pin_in, 0);
        eng_sda_low_in = 1'b0;
        r0 = rises;
        f0 = falls;
        i_hps_host_model.frame(3, 1'b1, 1'b1);
        w(6);
        chk("i2c_rises", 8'(rises - r0), 3);
        chk("i2c_falls", 8'(falls - f0), 3);
        chk("addr_held", i2c_target_addr_out, {I2C_ADDR_UPPER_RST, 2'b01});
        $display("test_i2c done");
    endtask
    task automatic test_oe();
        chk("en", clk_outputs_en_out, 1);
        output_disable_in = 1'b1;
        w(5);
        chk("en_off", clk_outputs_en_out, 0);
        output_disable_in = 1'b0;
        w(5);
        chk("en_on", clk_outputs_en_out, 1);
        $display("test_oe done");
    endtask
    task automatic test_status();
        ref_run = 3'b111;
        pll_locked_in = 1'b1;
        w(300);
        chk("lock", lock_lost_n_out, 1);
        chk("los", {input2_clock_lost_n_out, input1_clock_lost_n_out,
            input0_clock_lost_n_out}, 3'b111);
        chk("irq_set", status_change_irq_n_out, 0);
        irq_clear_in = 1'b1;
        w(1);
        irq_clear_in = 1'b0;
        w(3);
        chk("irq_clr", status_change_irq_n_out, 1);
        ref_run = 3'b101;
        w(2100);
        chk("los1", {input2_clock_lost_n_out, input1_clock_lost_n_out,
            input0_clock_lost_n_out}, 3'b101);
        chk("irq_los", status_change_irq_n_out, 0);
        pll_locked_in = 1'b0;
        w(5);
        chk("unlock", lock_lost_n_out, 0);
        $display("test_status done");
    endtask
    task automatic test_spi();
        chk("mode4", mode_out, HPS_MODE_SPI4);
        r0 = rises;
        f0 = falls;
        i_hps_host_model.frame(4, 1'b1, 1'b0);
        w(6);
        chk("cs_high_rises", 8'(rises - r0), 0);
        chk("cs_high_falls", 8'(falls - f0), 0);
        chk("cs_high_oe", sdo_addr1_oe_out, 0);
        r0 = rises;
        f0 = falls;
        fork
            i_hps_host_model.frame(5, 1'b1, 1'b1);
            begin
                w(8);
                chk("fa", frame_active_out, 1);
                chk("sdo_oe4", sdo_addr1_oe_out, 1);
                chk("sdi_oe4", data_pin_oe_out, 0);
                chk("bit_data", bit_data_out, 1);
            end
        join
        w(6);
        chk("spi_rises", 8'(rises - r0), 5);
        chk("spi_falls", 8'(falls - f0), 5);
        chk("sdo_rel", sdo_addr1_oe_out, 0);
        spi_4wire_val_in = 1'b0;
        spi_4wire_wr_in = 1'b1;
        w(1);
        spi_4wire_wr_in = 1'b0;
        eng_rd_oe_in = 1'b1;
        eng_rd_data_in = 1'b1;
        w(2);
        chk("mode3", mode_out, HPS_MODE_SPI3);
        fork
            i_hps_host_model.frame(2, 1'b0, 1'b1);
            begin
                w(8);
                chk("sdio_oe", data_pin_oe_out, 1);
                chk("sdio", data_pin_out, 1);
                chk("sdo_oe3", sdo_addr1_oe_out, 0);
            end
        join
        eng_rd_oe_in = 1'b0;
        $display("test_spi done");
    endtask
    // ************************
    // Main sequence and watchdog
    // ************************
    initial begin
        do_reset(1'b1);
        test_i2c();
        test_oe();
        test_status();
        do_reset(1'b0);
        test_spi();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        test_done();
    end
endmodule
